// ==== design/lbc_exec.sv ====
// lbc_exec.sv - executes AND, bit clear/set, skip-if-clear and direct call
// assumes: fetch presents one decoded instruction per cycle with instr_valid;
// register file read data for instr.raddr arrives combinationally on rf_rdata
`timescale 1ns/1ns
`include "lbc_map.svh"
module lbc_exec #(
  parameter int STACK_DEPTH = `LBC_STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction from fetch
  input wire logic instr_valid,
  input wire lbc_pkg::lbc_instr_t instr,
  // accumulator load from the rest of the core
  input wire lbc_pkg::lbc_acc_ld_t acc_ld,
  // register file read
  input wire logic [7:0] rf_rdata,
  // register file write
  output lbc_pkg::lbc_rf_wr_t rf_wr,
  // core state
  output logic [7:0] acc,
  output logic [2:0] flags,
  output logic [7:0] pc_high_byte_latch,
  // program counter control
  output logic pc_load,
  output logic [`LBC_PC_W-1:0] pc_target,
  output logic flush,
  output logic busy,
  // stack view
  output lbc_pkg::lbc_push_t push_out,
  output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr,
  output logic [`LBC_PC_W-1:0] stack_top
);
  import lbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction : bit_mask

  function automatic logic [2:0] flags_zero(input logic [2:0] f, input logic [7:0] res);
    flags_zero = f;
    flags_zero[`LBC_FLAG_Z] = (res == 8'h00);
  endfunction : flags_zero

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] acc_ff, nxt_acc;
  logic [2:0] flags_ff, nxt_flags;
  logic [7:0] latch_ff, nxt_latch;
  lbc_rf_wr_t rf_wr_ff, nxt_rf_wr;
  lbc_push_t push_ff, nxt_push;
  logic pc_load_ff, nxt_pc_load;
  logic [`LBC_PC_W-1:0] pc_target_ff, nxt_pc_target;
  logic flush_ff, nxt_flush;
  logic busy_ff, nxt_busy;
  logic [7:0] and_res;
  logic [$clog2(STACK_DEPTH)-1:0] sp_w;
  logic [`LBC_PC_W-1:0] top_w;

  assign and_res = acc_ff & ((instr.op == LBC_OP_AND_LIT) ? instr.imm : rf_rdata);

  ////////////////////////////////////////////////////////////////////////////
  // execute one instruction; busy marks the discarded second cycle
  always_comb begin
    nxt_acc = acc_ff;
    nxt_flags = flags_ff;
    nxt_latch = latch_ff;
    nxt_rf_wr = '0;
    nxt_push = '0;
    nxt_pc_load = 1'b0;
    nxt_pc_target = pc_target_ff;
    nxt_flush = 1'b0;
    nxt_busy = 1'b0;
    // other units load the accumulator; an AND result taken this cycle wins
    if (acc_ld.load) begin
      nxt_acc = acc_ld.data;
    end
    if (instr_valid && !busy_ff) begin
      unique case (instr.op)
        LBC_OP_NOP: begin
        end
        LBC_OP_AND_REG: begin
          nxt_flags = flags_zero(flags_ff, and_res);
          if (instr.dest) begin
            nxt_rf_wr = '{we: 1'b1, addr: instr.raddr, data: and_res};
          end else begin
            nxt_acc = and_res;
          end
        end
        LBC_OP_AND_LIT: begin
          nxt_acc = and_res;
          nxt_flags = flags_zero(flags_ff, and_res);
        end
        LBC_OP_BIT_CLR: begin
          nxt_rf_wr = '{we: 1'b1, addr: instr.raddr,
                        data: rf_rdata & ~bit_mask(instr.bitsel)};
        end
        LBC_OP_BIT_SET: begin
          nxt_rf_wr = '{we: 1'b1, addr: instr.raddr,
                        data: rf_rdata | bit_mask(instr.bitsel)};
        end
        LBC_OP_TEST_CLR: begin
          if ((rf_rdata & bit_mask(instr.bitsel)) == 8'h00) begin
            nxt_flush = 1'b1;
            nxt_busy = 1'b1;
          end
        end
        LBC_OP_CALL: begin
          nxt_push = '{push: 1'b1, addr: instr.pc + `LBC_PC_W'(1)};
          nxt_pc_target = {latch_ff[`LBC_LATCH_LO:0], instr.imm};
          nxt_pc_load = 1'b1;
          nxt_flush = 1'b1;
          nxt_busy = 1'b1;
        end
        LBC_OP_LATCH_WR: begin
          nxt_latch = instr.imm;
        end
      endcase
    end
  end

  // register execute results
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= `LBC_ACC_RST;
      flags_ff <= `LBC_FLAGS_RST;
      latch_ff <= `LBC_LATCH_RST;
      rf_wr_ff <= '0;
      push_ff <= '0;
      pc_load_ff <= 1'b0;
      pc_target_ff <= `LBC_PC_RST;
      flush_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      flags_ff <= nxt_flags;
      latch_ff <= nxt_latch;
      rf_wr_ff <= nxt_rf_wr;
      push_ff <= nxt_push;
      pc_load_ff <= nxt_pc_load;
      pc_target_ff <= nxt_pc_target;
      flush_ff <= nxt_flush;
      busy_ff <= nxt_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack
  lbc_stack #(.DEPTH(STACK_DEPTH)) u_stack (
    .clk(clk),
    .rst(rst),
    .push_in(push_ff),
    .sp(sp_w),
    .top(top_w)
  );

  assign rf_wr = rf_wr_ff;
  assign acc = acc_ff;
  assign flags = flags_ff;
  assign pc_high_byte_latch = latch_ff;
  assign pc_load = pc_load_ff;
  assign pc_target = pc_target_ff;
  assign flush = flush_ff;
  assign busy = busy_ff;
  assign push_out = push_ff;
  assign stack_ptr = sp_w;
  assign stack_top = top_w;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic take;
  assign take = instr_valid && !busy_ff;

  sequence s_call_taken;
    take && instr.op == LBC_OP_CALL;
  endsequence

  sequence s_call_done;
    pc_load_ff && push_ff.push && busy_ff ##1 !busy_ff;
  endsequence

  chk_and_dest: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_AND_REG && instr.dest && !acc_ld.load |=>
      rf_wr_ff.we && rf_wr_ff.data == $past(and_res) && acc_ff == $past(acc_ff))
    else $error("register AND to register wrong");
  chk_and_flags: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_AND_REG |=>
      flags_ff[1:0] == $past(flags_ff[1:0]) && flags_ff[2] == ($past(and_res) == 8'h00))
    else $error("register AND flags wrong");
  chk_lit_and: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_AND_LIT |=> acc_ff == $past(acc_ff & instr.imm))
    else $error("literal AND result wrong");
  chk_bit_clear: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_BIT_CLR |=>
      rf_wr_ff.we && !rf_wr_ff.data[$past(instr.bitsel)] && flags_ff == $past(flags_ff))
    else $error("bit clear wrong");
  chk_bit_set: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_BIT_SET |=>
      rf_wr_ff.we && rf_wr_ff.data[$past(instr.bitsel)] && flags_ff == $past(flags_ff))
    else $error("bit set wrong");
  chk_skip_flush: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_TEST_CLR && !rf_rdata[instr.bitsel] |=>
      flush_ff && busy_ff ##1 !busy_ff)
    else $error("skip did not flush");
  chk_noskip_one: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_TEST_CLR && rf_rdata[instr.bitsel] |=> !busy_ff && !flush_ff)
    else $error("set bit stalled");
  chk_call_target: assert property (@(posedge clk) disable iff (rst)
    s_call_taken |=> pc_target_ff == {$past(latch_ff[1:0]), $past(instr.imm)})
    else $error("call target wrong");
  chk_call_seq: assert property (@(posedge clk) disable iff (rst)
    s_call_taken |=> s_call_done)
    else $error("call not two cycles");
  chk_lit_zero: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_AND_LIT |=>
      flags_ff[2] == (acc_ff == 8'h00) && flags_ff[1:0] == $past(flags_ff[1:0]))
    else $error("literal AND flags wrong");
  chk_busy_ignore: assert property (@(posedge clk) disable iff (rst)
    busy_ff |=> !rf_wr_ff.we && !push_ff.push && !pc_load_ff && !busy_ff &&
      flags_ff == $past(flags_ff))
    else $error("discarded slot had an effect");
  chk_latch_write: assert property (@(posedge clk) disable iff (rst)
    take && instr.op == LBC_OP_LATCH_WR |=> latch_ff == $past(instr.imm))
    else $error("latch write wrong");
endmodule : lbc_exec

// ==== design/lbc_stack.sv ====
// lbc_stack.sv - return address stack held in flip-flops
// assumes: one push per cycle at most, overflow wraps the pointer
`timescale 1ns/1ns
`include "lbc_map.svh"
module lbc_stack #(
  parameter int DEPTH = `LBC_STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // push side
  input wire lbc_pkg::lbc_push_t push_in,
  // state
  output logic [$clog2(DEPTH)-1:0] sp,
  output logic [`LBC_PC_W-1:0] top
);
  import lbc_pkg::*;
  localparam int SPW = $clog2(DEPTH);
  logic [`LBC_PC_W-1:0] mem_ff [DEPTH];
  logic [`LBC_PC_W-1:0] nxt_mem [DEPTH];
  logic [SPW-1:0] sp_ff, nxt_sp;
  logic [`LBC_PC_W-1:0] top_ff, nxt_top;

  // next pointer and contents on a push
  always_comb begin
    nxt_mem = mem_ff;
    nxt_sp = sp_ff;
    nxt_top = top_ff;
    if (push_in.push) begin
      nxt_mem[sp_ff] = push_in.addr;
      nxt_sp = sp_ff + SPW'(1);
      nxt_top = push_in.addr;
    end
  end

  // register the stack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      sp_ff <= '0;
      top_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
      sp_ff <= nxt_sp;
      top_ff <= nxt_top;
    end
  end

  assign sp = sp_ff;
  assign top = top_ff;

  chk_push_advance: assert property (@(posedge clk) disable iff (rst)
    push_in.push |=> sp_ff == $past(sp_ff) + SPW'(1))
    else $error("stack pointer did not advance on push");
endmodule : lbc_stack

// ==== include/lbc_map.svh ====
// lbc_map.svh - offsets, field positions, reset values and counts of the executor
// assumes: included by the lbc package and design files by bare name
// What this block does
// - register AND combines accumulator with register; d=0 to accumulator, d=1 to register
// - register AND changes only zero flag, keeps carry and digit carry, one cycle
// - literal AND combines accumulator with 8-bit literal into accumulator, zero flag, one cycle
// - bit clear forces bit 0..7 of register 0..63 low, flags untouched, one cycle
// - bit set forces bit 0..7 of register 0..63 high, flags untouched, one cycle
// - skip-if-clear with bit zero discards prefetched instruction, runs a no-op, no flags
// - skip-if-clear takes one cycle when bit set, two when skipping
// - call pushes program counter plus one and advances stack pointer, flags untouched
// - call loads address into pc[7:0] and latch bits [1:0] into pc[9:8]
// - a program counter high-byte latch supplies upper target bits for call
`ifndef LBC_MAP_SVH
`define LBC_MAP_SVH

`define LBC_PC_W 10
`define LBC_RADDR_W 6
`define LBC_SP_W 3
`define LBC_STACK_DEPTH 8
`define LBC_FLAG_Z 2
`define LBC_FLAG_DC 1
`define LBC_FLAG_C 0
`define LBC_LATCH_LO 1
`define LBC_ACC_RST 8'h00
`define LBC_FLAGS_RST 3'h0
`define LBC_PC_RST 10'h000
`define LBC_LATCH_RST 8'h00
`define LBC_CALL_CYCLES 2
`define LBC_SKIP_CYCLES 2

`endif

// ==== include/lbc_pkg.sv ====
// lbc_pkg.sv - types shared by the executor and its stack
// assumes: lbc_map.svh is on the include path
`include "lbc_map.svh"
package lbc_pkg;
  typedef enum logic [2:0] {
    LBC_OP_NOP,
    LBC_OP_AND_REG,
    LBC_OP_AND_LIT,
    LBC_OP_BIT_CLR,
    LBC_OP_BIT_SET,
    LBC_OP_TEST_CLR,
    LBC_OP_CALL,
    LBC_OP_LATCH_WR
  } lbc_op_t;

  // one decoded instruction from the fetch stage
  typedef struct packed {
    lbc_op_t op;
    logic [5:0] raddr;
    logic [2:0] bitsel;
    logic dest;
    logic [7:0] imm;
    logic [9:0] pc;
  } lbc_instr_t;

  // register file write request
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] data;
  } lbc_rf_wr_t;

  // stack push request
  typedef struct packed {
    logic push;
    logic [9:0] addr;
  } lbc_push_t;

  // accumulator load from the rest of the core
  typedef struct packed {
    logic load;
    logic [7:0] data;
  } lbc_acc_ld_t;
endpackage : lbc_pkg

// ==== tb/lbc_rf_model.sv ====
// lbc_rf_model.sv - register file standing behind the executor
// assumes: read is combinational on the address, a write lands on the clock edge
`timescale 1ns/1ns
module lbc_rf_model (
  // clock
  input wire logic clk,
  // access
  input wire logic [5:0] raddr,
  input wire lbc_pkg::lbc_rf_wr_t wr,
  output logic [7:0] rdata
);
  import lbc_pkg::*;
  logic [7:0] mem [64];
  // fill once, then take write pulses; no reset so contents survive
  always @(posedge clk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
  end
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 37 + 5);
  end
  // read for the instruction now presented
  assign rdata = mem[raddr];
endmodule : lbc_rf_model

// ==== tb/tb_top.sv ====
// tb_top.sv - self-checking bench for the executor
// assumes: lbc_pkg and lbc_rf_model compiled before
`timescale 1ns/1ns
module tb_top;
  import lbc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  lbc_instr_t instr = '0;
  lbc_acc_ld_t acc_ld = '0;
  logic [7:0] rf_rdata, acc, latch, v, lat, im, x;
  lbc_rf_wr_t rf_wr;
  lbc_push_t push_out;
  logic [2:0] flags, sp0, stack_ptr, b, ef;
  logic [5:0] a;
  logic [9:0] pc_target, stack_top, pc;
  logic pc_load, flush, busy, d;
  int mismatches = 0;
  int checked = 0;
  ////////////////////////////////////////////////////////////
  // clock, design and register file
  always #20 clk = ~clk;
  lbc_exec #(.STACK_DEPTH(8)) uut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .acc_ld(acc_ld), .rf_rdata(rf_rdata), .rf_wr(rf_wr), .acc(acc),
    .flags(flags),
    .pc_high_byte_latch(latch), .pc_load(pc_load), .pc_target(pc_target), .flush(flush),
    .busy(busy), .push_out(push_out), .stack_ptr(stack_ptr), .stack_top(stack_top));
  lbc_rf_model rfm (.clk(clk), .raddr(instr.raddr), .wr(rf_wr), .rdata(rf_rdata));
  ////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [7:0] bit_op(logic [7:0] x, logic [2:0] n, logic s);
    return s ? (x | (8'h01 << n)) : (x & ~(8'h01 << n));
  endfunction : bit_op
  function automatic logic [9:0] call_tgt(logic [7:0] l, logic [7:0] adr);
    return {l[1:0], adr};
  endfunction : call_tgt
  // compare and count
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // present a slot; afterwards outputs show the instruction taken at this edge
  task automatic step(input logic vl, input lbc_op_t op, input logic [5:0] ra,
      input logic [2:0] bs, input logic de, input logic [7:0] ii, input logic [9:0] p);
    @(posedge clk);
    instr_valid <= vl;
    instr <= '{op, ra, bs, de, ii, p};
    #1;
  endtask : step
  // load the accumulator through the side port for one edge
  task automatic load_acc(input logic [7:0] val);
    @(posedge clk);
    acc_ld <= '{1'b1, val};
    @(posedge clk);
    acc_ld <= '0;
    #1;
  endtask : load_acc
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(32'h34a2));
    repeat (16) @(posedge clk);
    cmp({acc, latch}, 16'h0000);
    cmp({flags, stack_ptr}, 16'h0000);
    cmp({rf_wr.we, push_out.push, pc_load, flush, busy, pc_target}, 16'h0000);
    rst <= 1'b0;
    // register and, both destinations; first pass with a zero accumulator
    for (int k = 0; k < 8; k++) begin
      a = 6'($urandom);
      d = k[0];
      x = (k == 0) ? 8'h00 : 8'($urandom);
      load_acc(x);
      step(1, LBC_OP_AND_REG, a, 0, d, 0, 0);
      v = rfm.mem[a];
      step(0, LBC_OP_NOP, 0, 0, 0, 0, 0);
      ef = {(x & v) == 8'h00, 2'b00};
      cmp(rf_wr.we, d);
      if (d) cmp({rf_wr.addr, rf_wr.data}, {a, x & v});
      cmp(acc, d ? x : (x & v));
      cmp(flags, ef);
    end
    $display("test and_register done");
    // literal and; corners with a zero result and with an all-ones literal
    for (int k = 0; k < 4; k++) begin
      x = 8'($urandom);
      im = (k == 0) ? ~x : ((k == 1) ? 8'hff : 8'($urandom));
      load_acc(x);
      step(1, LBC_OP_AND_LIT, 0, 0, 0, im, 0);
      step(0, LBC_OP_NOP, 0, 0, 0, 0, 0);
      ef = {(x & im) == 8'h00, 2'b00};
      cmp({rf_wr.we, acc, flags}, {1'b0, x & im, ef});
    end
    $display("test and_literal done");
    // bit clear and set on every bit position
    for (int k = 0; k < 16; k++) begin
      a = 6'($urandom);
      b = k[2:0];
      step(1, k[3] ? LBC_OP_BIT_SET : LBC_OP_BIT_CLR, a, b, 0, 0, 0);
      v = rfm.mem[a];
      step(0, LBC_OP_NOP, 0, 0, 0, 0, 0);
      cmp({rf_wr.we, rf_wr.addr, rf_wr.data}, {1'b1, a, bit_op(v, b, k[3])});
      cmp({flags, busy, flush}, {ef, 2'b00});
    end
    $display("test bit_clear_set done");
    // skip-if-clear, with a bit set offered in the following slot
    a = 6'($urandom);
    for (int k = 0; k < 8; k++) begin
      b = k[2:0];
      step(1, LBC_OP_TEST_CLR, a, b, 0, 0, 0);
      v = rfm.mem[a];
      step(1, LBC_OP_BIT_SET, a ^ 6'h01, b, 0, 0, 0);
      cmp({flush, busy}, {!v[b], !v[b]});
      cmp(flags, ef);
      step(0, LBC_OP_NOP, 0, 0, 0, 0, 0);
      cmp({rf_wr.we, busy}, {v[b], 1'b0});
      step(0, LBC_OP_NOP, 0, 0, 0, 0, 0);
    end
    $display("test skip_if_clear done");
    // direct call through the latch, enough calls to wrap the stack pointer
    for (int k = 0; k < 9; k++) begin
      lat = 8'($urandom);
      im = 8'($urandom);
      pc = (k == 8) ? 10'h3ff : 10'($urandom);
      step(1, LBC_OP_LATCH_WR, 0, 0, 0, lat, 0);
      sp0 = stack_ptr;
      step(1, LBC_OP_CALL, 0, 0, 0, im, pc);
      cmp(latch, lat);
      step(1, LBC_OP_BIT_SET, 6'h01, 0, 0, 0, 0);
      cmp({push_out.push, push_out.addr}, {1'b1, pc + 10'h001});
      cmp({pc_load, pc_target}, {1'b1, call_tgt(lat, im)});
      cmp({flush, busy, flags}, {2'b11, ef});
      step(0, LBC_OP_NOP, 0, 0, 0, 0, 0);
      cmp({rf_wr.we, busy}, 2'b00);
      cmp({stack_ptr, stack_top}, {sp0 + 3'h1, pc + 10'h001});
    end
    $display("test call done");
    complete_run();
  end
endmodule : tb_top
